// ### common/lpi_pkg.sv
// Constants for the panel command receiver: command codes, masks, APB map.
// Assumes an 8-bit serial command stream and a 32-bit APB slave port.
package lpi_pkg;
  // Command codes of the power-on and power-off sequences
  localparam logic [7:0] CMD_BIAS_1_6 = 8'hA2;
  localparam logic [7:0] CMD_ADC_REVERSE = 8'hA1;
  localparam logic [7:0] CMD_COM_NORMAL = 8'hC0;
  localparam logic [7:0] CMD_BOOST_SET = 8'hF8;
  localparam logic [7:0] BOOST_RATIO_VAL = 8'h00;
  localparam logic [7:0] CMD_RATIO_5_0 = 8'h24;
  localparam logic [7:0] CMD_VOLUME_SET = 8'h81;
  localparam logic [7:0] CMD_POWER_STEP1 = 8'h2C;
  localparam logic [7:0] CMD_POWER_STEP2 = 8'h2E;
  localparam logic [7:0] CMD_POWER_STEP3 = 8'h2F;
  localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
  localparam logic [7:0] CMD_ALL_POINTS_ON = 8'hA5;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;
  // Masks that group a command family
  localparam logic [7:0] MASK_PAIR = 8'hFE;
  localparam logic [7:0] MASK_OCT = 8'hF8;
  localparam logic [7:0] MASK_NIB = 8'hF0;
  // Field positions and widths inside command bytes
  localparam int COM_DIR_BIT = 3;
  localparam int PWR_BOOST_BIT = 2;
  localparam int PWR_REG_BIT = 1;
  localparam int PWR_FOLLOW_BIT = 0;
  localparam int CONTRAST_W = 6;
  localparam int RATIO_W = 3;
  localparam int BOOST_W = 2;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  // Reset values of the panel settings
  localparam logic [CONTRAST_W-1:0] CONTRAST_RST = 6'h20;
  localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;
  localparam logic [BOOST_W-1:0] BOOST_RST = 2'h0;
  // APB map
  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] ADDR_CONFIG = 12'h000;
  localparam logic [APB_ADDR_W-1:0] ADDR_LEVELS = 12'h004;
  localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 12'h008;
  localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = 12'h00C;
  localparam int CTRL_ENFORCE_BIT = 0;
  localparam int CTRL_CLR_ERR_BIT = 1;
  localparam int DATA_CNT_W = 16;
  // Sequence tracker states
  typedef enum logic [3:0] {
    S_BIAS, S_ADC, S_COM, S_BOOST, S_BOOST_VAL, S_RATIO, S_VOL, S_VOL_VAL,
    S_PWR1, S_PWR2, S_PWR3, S_DISP, S_RUN, S_SAVE_ALL, S_SAVED
  } lpi_state_t;
endpackage

// ### src/lpi_sequencer.sv
// Panel-side command receiver: serial link, init/power-off sequence tracker,
// panel settings and an APB status/control port.
// Assumes a 4-wire serial host (clock, select, data, command/data select)
// and an APB master on the system clock.
// Summary of operation
// - The first init byte is A2H and the panel then drives 1/6 bias.
// - The second byte is A1H and the panel reverses column to segment mapping.
// - The third byte is C0H and the panel scans commons in normal direction.
// - The host sends 24H and the panel sets regulator gain 5.0.
// - Power circuits enable by 2CH, 2EH, 2FH: booster, regulator, follower.
// - Before power-down the host sends AEH then A5H.
// - The byte after the contrast command carries a 6-bit level 0 to 63.
// - The three low bits of the power command enable booster, regulator, follower.
// - The lowest bit of the bias command selects one of two bias ratios.
`timescale 1ns/1ps
`default_nettype none
module lpi_sequencer
  import lpi_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic active_low_reset_pin,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic command_data_select,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bias_select,
  output logic segment_reverse,
  output logic common_scan_direction,
  output logic booster_circuit_enable,
  output logic regulator_circuit_enable,
  output logic follower_circuit_enable,
  output logic display_on,
  output logic all_points_on,
  output logic [CONTRAST_W-1:0] contrast_level,
  output logic init_complete,
  output logic power_save_ready
);

  // Link domain: bit counter, shifter, byte holding register, event toggle
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [8:0] byte_link_reg;
  logic byte_tgl_reg;

  // Select high ends a frame and discards a partial byte
  // The counter wraps after eight bits, so one frame may carry several bytes
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      shift_reg <= {shift_reg[5:0], spi_mosi};
    end
  end

  // Byte is handed over only once all eight bits are
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      byte_link_reg <= '0;
      byte_tgl_reg <= 1'b0;
    end else if (!spi_cs_n && bit_cnt_reg == LAST_BIT) begin
      byte_link_reg <= {command_data_select, shift_reg, spi_mosi};
      byte_tgl_reg <= ~byte_tgl_reg;
    end
  end

  // Toggle crossing; the byte register holds for seven link clocks after it
  // A new event needs the second and third stages to agree on a fresh level
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg, tgl_seen_reg;
  logic byte_event;
  logic [8:0] rx_word;
  always_ff @(posedge clock) begin
    if (rst) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= byte_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      if (tgl_s2_reg == tgl_s3_reg) begin
        tgl_seen_reg <= tgl_s3_reg;
      end
    end
  end
  assign byte_event = (tgl_s2_reg == tgl_s3_reg) && (tgl_s3_reg != tgl_seen_reg);
  assign rx_word = byte_link_reg;

  // Reset pin filter: low holds every panel setting at its reset value
  logic rp_s1_reg, rp_s2_reg, rp_s3_reg, rp_level_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      rp_s1_reg <= 1'b0;
      rp_s2_reg <= 1'b0;
      rp_s3_reg <= 1'b0;
      rp_level_reg <= 1'b0;
    end else begin
      rp_s1_reg <= active_low_reset_pin;
      rp_s2_reg <= rp_s1_reg;
      rp_s3_reg <= rp_s2_reg;
      if (rp_s2_reg == rp_s3_reg) begin
        rp_level_reg <= rp_s3_reg;
      end
    end
  end

  logic is_data;
  logic [7:0] rx_byte;
  logic soft_reset;
  logic panel_clear;
  assign is_data = rx_word[8];
  assign rx_byte = rx_word[7:0];
  // Soft reset command is never an ordering error and never a setting
  assign soft_reset = byte_event && !is_data && rx_byte == CMD_SOFT_RESET;
  assign panel_clear = rst || !rp_level_reg;

  // Sequence tracker
  lpi_state_t state_reg, state_next;
  logic in_order;
  logic enforce_reg;
  logic apply;

  always_comb begin
    state_next = state_reg;
    in_order = 1'b0;
    unique case (state_reg)
      S_BIAS: in_order = rx_byte == CMD_BIAS_1_6;
      S_ADC: in_order = rx_byte == CMD_ADC_REVERSE;
      S_COM: in_order = rx_byte == CMD_COM_NORMAL;
      S_BOOST: in_order = rx_byte == CMD_BOOST_SET;
      S_BOOST_VAL: in_order = 1'b1;
      S_RATIO: in_order = rx_byte == CMD_RATIO_5_0;
      S_VOL: in_order = rx_byte == CMD_VOLUME_SET;
      S_VOL_VAL: in_order = 1'b1;
      S_PWR1: in_order = rx_byte == CMD_POWER_STEP1;
      S_PWR2: in_order = rx_byte == CMD_POWER_STEP2;
      S_PWR3: in_order = rx_byte == CMD_POWER_STEP3;
      S_DISP: in_order = rx_byte == CMD_DISPLAY_ON;
      S_RUN, S_SAVE_ALL, S_SAVED: in_order = 1'b1;
    endcase
    if (is_data && state_reg != S_RUN) begin
      in_order = 1'b0;
    end
    if (byte_event && (in_order || !enforce_reg)) begin
      unique case (state_reg)
        S_BIAS: state_next = S_ADC;
        S_ADC: state_next = S_COM;
        S_COM: state_next = S_BOOST;
        S_BOOST: state_next = S_BOOST_VAL;
        S_BOOST_VAL: state_next = S_RATIO;
        S_RATIO: state_next = S_VOL;
        S_VOL: state_next = S_VOL_VAL;
        S_VOL_VAL: state_next = S_PWR1;
        S_PWR1: state_next = S_PWR2;
        S_PWR2: state_next = S_PWR3;
        S_PWR3: state_next = S_DISP;
        S_DISP: state_next = S_RUN;
        // Display off then all points on readies the panel for power-off
        // Any other command byte but soft reset, or data with enforcement off, falls back to normal run while waiting for all points on
        S_RUN: state_next = (!is_data && rx_byte == CMD_DISPLAY_OFF) ? S_SAVE_ALL : S_RUN;
        S_SAVE_ALL: state_next = (!is_data && rx_byte == CMD_ALL_POINTS_ON) ? S_SAVED : S_RUN;
        S_SAVED: state_next = S_SAVED;
      endcase
    end
  end
  assign apply = byte_event && !soft_reset && (in_order || !enforce_reg);

  always_ff @(posedge clock) begin
    if (panel_clear || soft_reset) begin
      state_reg <= S_BIAS;
    end else begin
      state_reg <= state_next;
    end
  end

  // Command decoder with two-byte command tracking
  logic pend_vol_reg, pend_boost_reg;
  logic [RATIO_W-1:0] reg_ratio_reg;
  logic [BOOST_W-1:0] boost_ratio_reg;
  logic is_cmd;
  assign is_cmd = apply && !is_data && !pend_vol_reg && !pend_boost_reg;

  // A value byte is taken by the next command byte; display data passes by

  always_ff @(posedge clock) begin
    if (panel_clear || soft_reset) begin
      pend_vol_reg <= 1'b0;
      pend_boost_reg <= 1'b0;
    end else if (apply && !is_data) begin
      pend_vol_reg <= is_cmd && rx_byte == CMD_VOLUME_SET;
      pend_boost_reg <= is_cmd && rx_byte == CMD_BOOST_SET;
    end
  end

  // Pin reset and the soft reset command both return every panel setting
  always_ff @(posedge clock) begin
    if (panel_clear || soft_reset) begin
      bias_select <= 1'b0;
      segment_reverse <= 1'b0;
      common_scan_direction <= 1'b0;
      display_on <= 1'b0;
      all_points_on <= 1'b0;
      booster_circuit_enable <= 1'b0;
      regulator_circuit_enable <= 1'b0;
      follower_circuit_enable <= 1'b0;
      contrast_level <= CONTRAST_RST;
      reg_ratio_reg <= RATIO_RST;
      boost_ratio_reg <= BOOST_RST;
    end else begin
      if (apply && !is_data && pend_vol_reg) begin
        contrast_level <= rx_byte[CONTRAST_W-1:0];
      end
      if (apply && !is_data && pend_boost_reg) begin
        boost_ratio_reg <= rx_byte[BOOST_W-1:0];
      end
      if (is_cmd && (rx_byte & MASK_PAIR) == (CMD_BIAS_1_6 & MASK_PAIR)) begin
        bias_select <= rx_byte[0];
      end
      if (is_cmd && (rx_byte & MASK_PAIR) == (CMD_ADC_REVERSE & MASK_PAIR)) begin
        segment_reverse <= rx_byte[0];
      end
      if (is_cmd && (rx_byte & MASK_NIB) == (CMD_COM_NORMAL & MASK_NIB)) begin
        common_scan_direction <= rx_byte[COM_DIR_BIT];
      end
      if (is_cmd && (rx_byte & MASK_PAIR) == (CMD_DISPLAY_ON & MASK_PAIR)) begin
        display_on <= rx_byte[0];
      end
      if (is_cmd && (rx_byte & MASK_PAIR) == (CMD_ALL_POINTS_ON & MASK_PAIR)) begin
        all_points_on <= rx_byte[0];
      end
      if (is_cmd && (rx_byte & MASK_OCT) == (CMD_POWER_STEP1 & MASK_OCT)) begin
        booster_circuit_enable <= rx_byte[PWR_BOOST_BIT];
        regulator_circuit_enable <= rx_byte[PWR_REG_BIT];
        follower_circuit_enable <= rx_byte[PWR_FOLLOW_BIT];
      end
      if (is_cmd && (rx_byte & MASK_OCT) == (CMD_RATIO_5_0 & MASK_OCT)) begin
        reg_ratio_reg <= rx_byte[RATIO_W-1:0];
      end
    end
  end

  // Sequence flags and display data byte counter
  // Only applied display data bytes are counted
  logic seq_error_reg;
  logic clr_err;
  logic [DATA_CNT_W-1:0] data_cnt_reg;
  always_ff @(posedge clock) begin
    if (panel_clear || soft_reset) begin
      init_complete <= 1'b0;
      power_save_ready <= 1'b0;
      data_cnt_reg <= '0;
    end else begin
      init_complete <= state_next == S_RUN || state_next == S_SAVE_ALL ||
                       state_next == S_SAVED;
      power_save_ready <= state_next == S_SAVED;
      if (apply && is_data) begin
        data_cnt_reg <= data_cnt_reg + 1'b1;
      end
    end
  end

  // Error set wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_error_reg <= 1'b0;
    end else if (byte_event && !in_order && !soft_reset) begin
      seq_error_reg <= 1'b1;
    end else if (clr_err) begin
      seq_error_reg <= 1'b0;
    end
  end

  // APB slave, one wait state per access
  // Read data and error are zero outside the ready cycle
  logic access;
  logic addr_ok;
  logic [31:0] rdata_next;
  assign access = psel && penable && pready;
  assign addr_ok = paddr == ADDR_CONFIG || paddr == ADDR_LEVELS || paddr == ADDR_STATUS || paddr == ADDR_CTRL;
  assign clr_err = access && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_CLR_ERR_BIT];

  always_comb begin
    rdata_next = '0;
    unique case (paddr)
      ADDR_CONFIG: rdata_next = {24'h000000, all_points_on, display_on, follower_circuit_enable,
                                 regulator_circuit_enable, booster_circuit_enable,
                                 common_scan_direction, segment_reverse, bias_select};
      ADDR_LEVELS: rdata_next = {18'h00000, boost_ratio_reg, 1'b0,
                                 reg_ratio_reg, 2'h0,
                                 contrast_level};
      ADDR_STATUS: rdata_next = {data_cnt_reg, 10'h000,
                                 pend_boost_reg, pend_vol_reg, ~rp_level_reg,
                                 seq_error_reg, power_save_ready, init_complete};
      ADDR_CTRL: rdata_next = {30'h00000000, 1'b0, enforce_reg};
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rdata_next;
        pslverr <= !addr_ok;
      end else begin
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // Order enforcement: out-of-order bytes are flagged and dropped
  // With enforcement off such bytes still pass but are flagged all the same
  always_ff @(posedge clock) begin
    if (rst) begin
      enforce_reg <= 1'b0;
    end else if (access && pwrite && paddr == ADDR_CTRL) begin
      enforce_reg <= pwdata[CTRL_ENFORCE_BIT];
    end
  end

endmodule // lpi_sequencer
`default_nettype wire

// ### verif/lpi_host_model.sv
// Host side of the serial command link: shifts bytes MSB first.
// Assumes the bench calls send() and leaves gaps between bytes.
`timescale 1ns/1ps
`default_nettype none
module lpi_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic command_data_select
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    command_data_select = 1'b0;
  end
  // Link clock runs only inside a frame, 15 ns period
  task automatic send(input logic [7:0] b, input logic dc);
    integer i;
    spi_cs_n = 1'b0;
    #3.3;
    for (i = 7; i >= 0; i--) begin
      spi_mosi = b[i];
      command_data_select = dc;
      #7.5 spi_sclk = 1'b1;
      #7.5 spi_sclk = 1'b0;
    end
    #7.5 spi_cs_n = 1'b1;
    // Released lines show the inverse of the last value
    spi_mosi = ~spi_mosi;
    command_data_select = ~dc;
  endtask
endmodule // lpi_host_model
`default_nettype wire

// ### verif/lpi_sequencer_monitor.sv
// Concurrent checks on the ports of the panel command receiver.
// Assumes binding into lpi_sequencer; all checks on the system clock.
`timescale 1ns/1ps
`default_nettype none
module lpi_sequencer_monitor
  import lpi_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic active_low_reset_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic booster_circuit_enable,
  input wire logic regulator_circuit_enable,
  input wire logic follower_circuit_enable,
  input wire logic display_on,
  input wire logic all_points_on,
  input wire logic [CONTRAST_W-1:0] contrast_level,
  input wire logic init_complete,
  input wire logic power_save_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; s_setup ##1 (psel && penable); endsequence
  sequence s_pin_low; !active_low_reset_pin [*8]; endsequence
  property p_one_wait; s_access |=> pready; endproperty
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  property p_idle_zero; !pready |-> (prdata == 32'h0) && !pslverr; endproperty
  property p_rst_vals; $past(rst) |-> (contrast_level == CONTRAST_RST) && !display_on && !init_complete; endproperty
  property p_pin_clears; s_pin_low |=> (contrast_level == CONTRAST_RST) && !display_on && !booster_circuit_enable;
  endproperty
  property p_init_done; $rose(init_complete) |-> display_on && booster_circuit_enable && regulator_circuit_enable
    && follower_circuit_enable; endproperty
  property p_save; $rose(power_save_ready) |-> !display_on && all_points_on; endproperty
  property p_save_in_run; power_save_ready |-> init_complete; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  a_idle_zero: assert property (p_idle_zero) else $error("idle read data not zero");
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_pin_clears: assert property (p_pin_clears) else $error("pin reset ignored");
  a_init_done: assert property (p_init_done) else $error("init done early");
  a_save: assert property (p_save) else $error("power save state wrong");
  a_save_in_run: assert property (p_save_in_run) else $error("power save outside run");
endmodule // lpi_sequencer_monitor
bind lpi_sequencer lpi_sequencer_monitor i_mon (.clock(clock), .rst(rst),
  .active_low_reset_pin(active_low_reset_pin), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .booster_circuit_enable(booster_circuit_enable),
  .regulator_circuit_enable(regulator_circuit_enable), .follower_circuit_enable(follower_circuit_enable),
  .display_on(display_on), .all_points_on(all_points_on), .contrast_level(contrast_level),
  .init_complete(init_complete), .power_save_ready(power_save_ready));
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench: power-on sequence, power save, pin reset, order errors.
// Assumes lpi_sequencer, the host model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb
  import lpi_pkg::*;
;
  localparam logic [7:0] LEVEL = 8'h12;
  logic clock, rst, pin, sclk, cs_n, mosi, dcs, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bias, seg, com, bst, reg_on, fol, disp, allp, done, psr;
  logic [5:0] lvl;
  int fail_count = 0;
  int check_count = 0;
  // Power-on then power-save byte order and expected CONFIG bits
  logic [7:0] seq_b [14] = '{8'hA2, 8'hA1, 8'hC0, 8'hF8, 8'h00, 8'h24, 8'h81, LEVEL, 8'h2C, 8'h2E, 8'h2F,
    8'hAF, 8'hAE, 8'hA5};
  logic [7:0] seq_e [14] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h0A, 8'h1A, 8'h3A,
    8'h7A, 8'h3A, 8'hBA};
  lpi_host_model i_host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .command_data_select(dcs));
  lpi_sequencer i_dut (.clock(clock), .rst(rst), .active_low_reset_pin(pin), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .command_data_select(dcs), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bias_select(bias), .segment_reverse(seg), .common_scan_direction(com), .booster_circuit_enable(bst),
    .regulator_circuit_enable(reg_on), .follower_circuit_enable(fol), .display_on(disp),
    .all_points_on(allp), .contrast_level(lvl), .init_complete(done), .power_save_ready(psr));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic byte_out(input logic [7:0] b);
    i_host.send(b, 1'b0);
    repeat (10) @(posedge clock);
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (20) @(posedge clock);
    pin <= 1'b1;
    repeat (1000) @(posedge clock);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    for (int i = 0; i < 14; i++) begin
      if (i == 12) begin
        i_host.send(8'h55, 1'b1);
        repeat (10) @(posedge clock);
      end
      byte_out(seq_b[i]);
      `CHK({allp, disp, fol, reg_on, bst, com, seg, bias}, seq_e[i])
    end
    `CHK(lvl, LEVEL[5:0])
    apb(1'b0, ADDR_LEVELS, 32'h0);
    `CHK(rd, 32'h0400 | 32'(LEVEL[5:0]))
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h00010003)
    apb(1'b0, ADDR_CONFIG, 32'h0);
    `CHK(rd, 32'hBA)
    pin <= 1'b0;
    repeat (20) @(posedge clock);
    `CHK({done, psr, lvl}, {2'b00, CONTRAST_RST})
    pin <= 1'b1;
    repeat (20) @(posedge clock);
    apb(1'b1, ADDR_CTRL, 32'h1);
    byte_out(CMD_DISPLAY_ON);
    `CHK(disp, 1'b0)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd & 32'h4, 32'h4)
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd & 32'h4, 32'h0)
    byte_out(CMD_ADC_REVERSE);
    `CHK(seg, 1'b1)
    byte_out(CMD_SOFT_RESET);
    `CHK({seg, lvl}, {1'b0, CONTRAST_RST})
    conclude();
  end
endmodule // tb
`default_nettype wire
